// [include/ifr_pkg.sv]
/*
 * constants for the interrupt flag status block: register offsets,
 * flag bit positions, implemented-bit masks, reset values, bus answers.
 * assumes a 32-bit axi4-lite register bus with 8 decoded address bits.
 */
package ifr_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_FLAGS_LOW    = 8'h00;
    localparam logic [7:0]  OFF_FLAGS_SECOND = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h08;
    localparam logic [7:0]  OFF_IRQ_CLEAR    = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'h10;

    // ------------------------------------------------------------------
    // flag positions, first flag register
    // ------------------------------------------------------------------
    localparam int          BIT_OUT_CMP_ONE  = 2;
    localparam int          BIT_IN_CAP_ONE   = 1;
    localparam int          BIT_EXT_ZERO     = 0;

    // ------------------------------------------------------------------
    // flag positions, second flag register
    // ------------------------------------------------------------------
    localparam int          BIT_EXT_TWO      = 13;
    localparam int          BIT_TIMER_FIVE   = 12;
    localparam int          BIT_TIMER_FOUR   = 11;
    localparam int          BIT_EXT_ONE      = 4;
    localparam int          BIT_PIN_CHANGE   = 3;
    localparam int          BIT_COMPARATOR   = 2;
    localparam int          BIT_I2C_MASTER   = 1;
    localparam int          BIT_I2C_SLAVE    = 0;

    // status/clear/enable word: second flags sit in the upper half
    localparam int          SECOND_LSB       = 16;

    // ------------------------------------------------------------------
    // implemented-bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] MASK_LOW         = 16'h0007;
    localparam logic [15:0] MASK_SECOND      = 16'h381f;
    localparam logic [15:0] MASK_TIMER_PAIR  = 16'h1800;
    localparam logic [15:0] FLAGS_RST        = 16'h0000;
    localparam logic [31:0] ENABLE_RST       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage

// [rtl/ifr_pin_edge.sv]
/*
 * external interrupt pin conditioning: two-flop synchroniser per pin and
 * a rising-edge detector behind the second flop.
 * assumes pins are asynchronous to aclk and held at least two cycles.
 */
`timescale 1ns/100ps
module ifr_pin_edge #(
    parameter int WIDTH = 3
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] rise_pulse
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("ifr_pin_edge: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------------
    // synchroniser and edge detect
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] last_ff;
    logic [WIDTH-1:0] rise_ff;
    wire  [WIDTH-1:0] nxt_rise = sync_ff & ~last_ff;

    // meta_ff feeds only sync_ff
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
            rise_ff <= '0;
        end else begin
            meta_ff <= pin_async;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            rise_ff <= nxt_rise;
        end
    end

    assign rise_pulse = rise_ff;

endmodule // ifr_pin_edge

// [rtl/ifr_flag_regs.sv]
/*
 * interrupt request flag registers with an axi4-lite slave, a sticky
 * status view, write-one clear, enable mask and one level interrupt.
 * assumes peripheral events are one-cycle pulses on aclk and external
 * interrupt pins are asynchronous levels, flagged on their rising edge.
 */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module ifr_flag_regs
    import ifr_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter bit HAS_TIMERS = 1'b1
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              out_cmp_one_evt,
    input  wire logic              in_cap_one_evt,
    input  wire logic              timer_four_evt,
    input  wire logic              timer_five_evt,
    input  wire logic              pin_change_evt,
    input  wire logic              comparator_evt,
    input  wire logic              i2c_master_evt,
    input  wire logic              i2c_slave_evt,
    input  wire logic [2:0]        ext_pin,
    output logic                   irq
);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ifr_flag_regs: ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------------
    // external pins
    // ------------------------------------------------------------------
    logic [2:0] ext_rise;

    ifr_pin_edge #(
        .WIDTH      (3)
    ) u_pin_edge (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_async  (ext_pin),
        .rise_pulse (ext_rise)
    );

    // ------------------------------------------------------------------
    // event vectors
    // ------------------------------------------------------------------
    // timer pair bits vanish on small parts, so they also ignore writes
    wire [15:0] mask_second = HAS_TIMERS ? MASK_SECOND : (MASK_SECOND & ~MASK_TIMER_PAIR);
    wire [15:0] ev_low = (16'(out_cmp_one_evt) << BIT_OUT_CMP_ONE)
                       | (16'(in_cap_one_evt)  << BIT_IN_CAP_ONE)
                       | (16'(ext_rise[0])     << BIT_EXT_ZERO);
    wire [15:0] ev_raw = (16'(ext_rise[2])     << BIT_EXT_TWO)
                       | (16'(timer_five_evt)  << BIT_TIMER_FIVE)
                       | (16'(timer_four_evt)  << BIT_TIMER_FOUR)
                       | (16'(ext_rise[1])     << BIT_EXT_ONE)
                       | (16'(pin_change_evt)  << BIT_PIN_CHANGE)
                       | (16'(comparator_evt)  << BIT_COMPARATOR)
                       | (16'(i2c_master_evt)  << BIT_I2C_MASTER)
                       | (16'(i2c_slave_evt)   << BIT_I2C_SLAVE);
    wire [15:0] ev_second = ev_raw & mask_second;

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              aw_hold_ff;
    logic              w_hold_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;

    wire aw_take     = s_axi_awvalid & awready_ff;
    wire w_take      = s_axi_wvalid & wready_ff;
    // in the first cycle both halves are held; keeps the decode off the inputs
    wire do_write    = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire nxt_aw_hold = aw_take | (aw_hold_ff & ~do_write);
    wire nxt_w_hold  = w_take | (w_hold_ff & ~do_write);
    wire nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready);

    wire [7:0]  wr_off  = {aw_addr_ff[7:2], 2'b00};
    // shift, not a part-select: an empty upper slice is illegal at ADDR_W of 8
    wire        wr_hi0  = ((aw_addr_ff >> 8) == '0);
    wire        wr_low  = do_write & wr_hi0 & (wr_off == OFF_FLAGS_LOW);
    wire        wr_sec  = do_write & wr_hi0 & (wr_off == OFF_FLAGS_SECOND);
    wire        wr_clr  = do_write & wr_hi0 & (wr_off == OFF_IRQ_CLEAR);
    wire        wr_en   = do_write & wr_hi0 & (wr_off == OFF_IRQ_ENABLE);
    wire        wr_ro   = do_write & wr_hi0 & (wr_off == OFF_IRQ_STATUS);
    wire        wr_bad  = do_write & ~(wr_low | wr_sec | wr_clr | wr_en | wr_ro);
    wire [31:0] lane_m  = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                           {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire [31:0] clr_vec = wr_clr ? (w_data_ff & lane_m) : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            aw_addr_ff <= '0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            bvalid_ff  <= nxt_bvalid;
            awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
            if (do_write) bresp_ff <= wr_bad ? RESP_SLVERR : RESP_OKAY;
            if (aw_take) aw_addr_ff <= s_axi_awaddr;
            if (w_take) w_data_ff <= s_axi_wdata;
            if (w_take) w_strb_ff <= s_axi_wstrb;
        end
    end

    // ------------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------------
    logic [15:0] low_ff;
    logic [15:0] second_ff;
    logic [31:0] enable_ff;
    logic        irq_ff;

    wire [15:0] low_wr     = wr_low ? ((low_ff & ~lane_m[15:0]) | (w_data_ff[15:0] & lane_m[15:0]))
                                    : low_ff;
    wire [15:0] second_wr  = wr_sec ? ((second_ff & ~lane_m[15:0])
                                       | (w_data_ff[15:0] & lane_m[15:0]))
                                    : second_ff;
    // set wins over a write of zero or a clear in the same cycle
    wire [15:0] nxt_low    = ((low_wr & ~clr_vec[15:0]) & MASK_LOW) | ev_low;
    wire [15:0] nxt_second = ((second_wr & ~clr_vec[31:16]) & mask_second) | ev_second;
    wire [31:0] status_w   = {second_ff, low_ff};
    wire [31:0] nxt_enable = wr_en ? ((enable_ff & ~lane_m) | (w_data_ff & lane_m)) : enable_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_ff    <= FLAGS_RST;
            second_ff <= FLAGS_RST;
            enable_ff <= ENABLE_RST;
            irq_ff    <= 1'b0;
        end else begin
            low_ff    <= nxt_low;
            second_ff <= nxt_second;
            enable_ff <= nxt_enable;
            irq_ff    <= |(status_w & enable_ff);
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    wire        ar_take    = s_axi_arvalid & arready_ff;
    wire        nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    wire [7:0]  rd_off     = {s_axi_araddr[7:2], 2'b00};
    wire        rd_hi0     = ((s_axi_araddr >> 8) == '0);
    wire        rd_low     = rd_hi0 & (rd_off == OFF_FLAGS_LOW);
    wire        rd_sec     = rd_hi0 & (rd_off == OFF_FLAGS_SECOND);
    wire        rd_sts     = rd_hi0 & (rd_off == OFF_IRQ_STATUS);
    wire        rd_clr     = rd_hi0 & (rd_off == OFF_IRQ_CLEAR);
    wire        rd_en      = rd_hi0 & (rd_off == OFF_IRQ_ENABLE);
    wire        rd_ok      = rd_low | rd_sec | rd_sts | rd_clr | rd_en;
    // clear register is write-only and reads as zero
    wire [31:0] rd_mux     = rd_low ? {16'h0000, low_ff}
                           : rd_sec ? {16'h0000, second_ff}
                           : rd_sts ? status_w
                           : rd_en  ? enable_ff
                           : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take) rdata_ff <= rd_mux;
            if (ar_take) rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq           = irq_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_low_written;
        do_write && (wr_low || wr_clr);
    endsequence

    a_flag_sticky: assert property ($fell(low_ff[BIT_OUT_CMP_ONE]) |-> $past(wr_low || wr_clr))
        else $error("first register flag dropped without a write");
    a_outcmp_sets: assert property (out_cmp_one_evt |=> low_ff[BIT_OUT_CMP_ONE])
        else $error("output compare event did not set its flag");
    a_incap_sets: assert property (in_cap_one_evt |=> low_ff[BIT_IN_CAP_ONE])
        else $error("input capture event did not set its flag");
    a_ext0_sets: assert property ($rose(u_pin_edge.sync_ff[0]) |=> ##1 low_ff[BIT_EXT_ZERO])
        else $error("external input zero edge did not set its flag");
    a_ext2_sets: assert property (ext_rise[2] |=> second_ff[BIT_EXT_TWO])
        else $error("external input two edge did not set its flag");
    a_timer_sets: assert property ((timer_five_evt && HAS_TIMERS) |=> second_ff[BIT_TIMER_FIVE])
        else $error("timer five event did not set its flag");
    a_ext1_sets: assert property (ext_rise[1] |=> second_ff[BIT_EXT_ONE])
        else $error("external input one edge did not set its flag");
    a_change_cmp: assert property ((pin_change_evt || comparator_evt)
                                   |=> (second_ff[3:2] & $past({pin_change_evt, comparator_evt}))
                                       == $past({pin_change_evt, comparator_evt}))
        else $error("pin change or comparator flag not set");
    a_i2c_sets: assert property ((i2c_master_evt || i2c_slave_evt)
                                 |=> (second_ff[1:0] & $past({i2c_master_evt, i2c_slave_evt}))
                                     == $past({i2c_master_evt, i2c_slave_evt}))
        else $error("i2c event did not set its flag");
    a_unused_zero: assert property ((second_ff & ~mask_second) == 16'h0000
                                    && (low_ff & ~MASK_LOW) == 16'h0000)
        else $error("unimplemented flag bit reads one");
    a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
                                    !aresetn |=> (low_ff == FLAGS_RST && second_ff == FLAGS_RST))
        else $error("flags not cleared by reset");
    a_write_answer: assert property (s_low_written |=> bvalid_ff && bresp_ff == RESP_OKAY)
        else $error("flag write not answered");

    // ------------------------------------------------------------------
    // bus answers and interrupt output
    // ------------------------------------------------------------------
    // a lost or changed answer would hang or fool the processor side
    sequence s_read_taken;
        s_axi_arvalid && arready_ff;
    endsequence

    sequence s_resp_waiting;
        bvalid_ff && !s_axi_bready;
    endsequence

    sequence s_data_waiting;
        rvalid_ff && !s_axi_rready;
    endsequence

    sequence s_resp_taken;
        bvalid_ff && s_axi_bready;
    endsequence

    a_read_answer: assert property (s_read_taken |=> rvalid_ff && !arready_ff)
        else $error("read request not answered");
    a_resp_holds: assert property (s_resp_waiting |=> bvalid_ff && $stable(bresp_ff))
        else $error("write response dropped before it was taken");
    a_rdata_holds: assert property (s_data_waiting |=> rvalid_ff && $stable(rdata_ff))
        else $error("read data changed before it was taken");
    a_write_reopen: assert property (s_resp_taken |=> awready_ff && wready_ff)
        else $error("write channels not reopened after the response");
    a_irq_follows: assert property ((out_cmp_one_evt && enable_ff[BIT_OUT_CMP_ONE] && !wr_en)
                                    |=> ##1 irq_ff)
        else $error("enabled output compare flag did not raise the interrupt");
    a_irq_quiet: assert property ((status_w & enable_ff) == 32'h0000_0000 |=> !irq_ff)
        else $error("interrupt high with no enabled flag");

endmodule // ifr_flag_regs

// [testbench/ifr_evt_src.sv]
/*
 * peripheral event source model: one-cycle event pulses and external
 * interrupt pin levels, both on command of the bench.
 * assumes commands change right after a rising edge of aclk.
 */
`timescale 1ns/100ps
module ifr_evt_src (
    input  wire logic       aclk,
    input  wire logic [7:0] evt_req,
    input  wire logic [2:0] pin_lvl,
    output logic            out_cmp_one_evt,
    output logic            in_cap_one_evt,
    output logic            timer_four_evt,
    output logic            timer_five_evt,
    output logic            pin_change_evt,
    output logic            comparator_evt,
    output logic            i2c_master_evt,
    output logic            i2c_slave_evt,
    output logic [2:0]      ext_pin
);
    // ------------------------------------------------------------------
    // registered: a held level would re-set a flag, so pulses last one cycle
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        {i2c_slave_evt, i2c_master_evt, comparator_evt, pin_change_evt,
         timer_five_evt, timer_four_evt, in_cap_one_evt, out_cmp_one_evt} <= evt_req;
        ext_pin <= pin_lvl;
    end
endmodule // ifr_evt_src

// [testbench/ifr_flag_regs_tb.sv]
/*
 * self-checking bench for the interrupt flag registers: axi4-lite tasks,
 * event sources through the partner model, status, clear, enable, irq.
 * assumes the default register map; a second instance without the timer
 * pair runs in lockstep on the same bus and sources.
 */
`timescale 1ns/100ps
module ifr_flag_regs_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd, ex;
    logic [31:0] rdata_s;
    logic [1:0]  rsp;
    logic [7:0]  evt_req = 8'h00;
    logic [2:0]  pin_lvl = 3'h0;
    logic        oc1, ic1, t4, t5, cn, cm, i2m, i2s;
    logic [2:0]  pins;
    logic [4:0]  pos;
    int          bad_count = 0, check_count = 0, cyc = 0;

    always #4 aclk = ~aclk;

    ifr_evt_src src (.aclk(aclk), .evt_req(evt_req), .pin_lvl(pin_lvl),
        .out_cmp_one_evt(oc1), .in_cap_one_evt(ic1), .timer_four_evt(t4),
        .timer_five_evt(t5), .pin_change_evt(cn), .comparator_evt(cm),
        .i2c_master_evt(i2m), .i2c_slave_evt(i2s), .ext_pin(pins));

    ifr_flag_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .out_cmp_one_evt(oc1), .in_cap_one_evt(ic1),
        .timer_four_evt(t4), .timer_five_evt(t5), .pin_change_evt(cn),
        .comparator_evt(cm), .i2c_master_evt(i2m), .i2c_slave_evt(i2s),
        .ext_pin(pins), .irq(irq));

    // small part: same handshake timing, so its read data is valid with dut's
    ifr_flag_regs #(.HAS_TIMERS(1'b0)) dut_small (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_s), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(rready), .out_cmp_one_evt(oc1),
        .in_cap_one_evt(ic1), .timer_four_evt(t4), .timer_five_evt(t5),
        .pin_change_evt(cn), .comparator_evt(cm), .i2c_master_evt(i2m),
        .i2c_slave_evt(i2s), .ext_pin(pins), .irq());

    // ------------------------------------------------------------------
    // report and bus tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // no fixed latency assumed: waits for bvalid, the timeout cuts a hang
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rsp);
        chk(name, exp, rd);
    endtask

    // one pulse, or a pin held long enough for the synchroniser
    task automatic fire(input int i);
        @(posedge aclk);
        if (i < 8) evt_req <= 8'(1 << i);
        else pin_lvl <= 3'(1 << (i - 8));
        @(posedge aclk);
        evt_req <= 8'h00;
        repeat (6) @(posedge aclk);
        pin_lvl <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask

    // source index -> {second register, bit position}
    function automatic logic [4:0] src_pos(input int i);
        case (i)
            0: return {1'b0, 4'd2};
            1: return {1'b0, 4'd1};
            2: return {1'b1, 4'd11};
            3: return {1'b1, 4'd12};
            4: return {1'b1, 4'd3};
            5: return {1'b1, 4'd2};
            6: return {1'b1, 4'd1};
            7: return {1'b1, 4'd0};
            8: return {1'b0, 4'd0};
            9: return {1'b1, 4'd4};
            default: return {1'b1, 4'd13};
        endcase
    endfunction

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("first flags at reset", 8'h00, 32'h0);
        rd_chk("second flags at reset", 8'h04, 32'h0);
        rd_chk("enable at reset", 8'h10, 32'h0);
        for (int i = 0; i < 11; i++) begin
            pos = src_pos(i);
            ex = 32'h1 << pos[3:0];
            fire(i);
            rd_chk("flag register", pos[4] ? 8'h04 : 8'h00, ex);
            chk("small part flag", (i == 2 || i == 3) ? 32'h0 : ex, rdata_s);
            rd_chk("status", 8'h08, pos[4] ? ex << 16 : ex);
            chk("irq while disabled", 32'h0, {31'h0, irq});
            if (i % 2 == 0) axi_wr(pos[4] ? 8'h04 : 8'h00, 32'h0, rsp);
            else axi_wr(8'h0c, pos[4] ? ex << 16 : ex, rsp);
            rd_chk("status after clear", 8'h08, 32'h0);
        end
        axi_wr(8'h04, 32'h0000_ffff, rsp);
        rd_chk("second writable bits", 8'h04, 32'h0000_381f);
        chk("small part writable bits", 32'h0000_201f, rdata_s);
        axi_wr(8'h00, 32'h0000_ffff, rsp);
        rd_chk("first writable bits", 8'h00, 32'h0000_0007);
        axi_wr(8'h0c, 32'hffff_ffff, rsp);
        rd_chk("clear all", 8'h08, 32'h0);
        rd_chk("clear reads zero", 8'h0c, 32'h0);
        axi_wr(8'h10, 32'h0000_0004, rsp);
        fire(5);
        chk("irq masked", 32'h0, {31'h0, irq});
        fire(0);
        chk("irq enabled", 32'h1, {31'h0, irq});
        axi_wr(8'h0c, 32'h0000_0004, rsp);
        repeat (2) @(posedge aclk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        rd_chk("masked flag stays", 8'h08, 32'h0004_0000);
        axi_wr(8'h08, 32'hffff_ffff, rsp);
        chk("status write response", 32'h0, {30'h0, rsp});
        rd_chk("status write ignored", 8'h08, 32'h0004_0000);
        axi_wr(8'h20, 32'hffff_ffff, rsp);
        chk("unmapped write response", 32'h2, {30'h0, rsp});
        axi_rd(8'h20, rd, rsp);
        chk("unmapped read response", 32'h2, {30'h0, rsp});
        chk("unmapped read data", 32'h0, rd);
        fire(10);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("second flags after reset", 8'h04, 32'h0);
        rd_chk("status after reset", 8'h08, 32'h0);
        conclude();
    end
endmodule // ifr_flag_regs_tb
